// ==== hw/adt_pkg.sv ====
// Register map, fields, reset values and codes of the timer
package adt_pkg;

    // Register byte offsets
    localparam logic [7:0] ADR_RELOAD    = 8'h00;
    localparam logic [7:0] ADR_COUNTER   = 8'h04;
    localparam logic [7:0] ADR_CTRL      = 8'h0C;
    localparam logic [7:0] ADR_FLAGS     = 8'h10;
    localparam logic [7:0] ADR_FLAG_CLR  = 8'h14;
    localparam logic [7:0] ADR_SLAVE     = 8'h18;
    localparam logic [7:0] ADR_OUTFLT    = 8'h1C;
    localparam logic [7:0] ADR_CHAN_CTRL = 8'h24;
    localparam logic [7:0] ADR_DEAD      = 8'h30;
    localparam logic [7:0] ADR_CCR_BASE  = 8'h3C;
    localparam logic [7:0] ADR_STEP      = 8'h04;

    // Control register fields
    localparam int CR_EN       = 0;
    localparam int CR_MODE     = 2;
    localparam int CR_COMP     = 4;
    localparam int CR_PAIR_SEL = 5;
    localparam int CR_TRIG_IE  = 19;
    localparam int CR_SW_TRIG  = 24;
    localparam int CR_SW_UPD   = 25;
    localparam int CR_DIR      = 27;
    localparam logic [31:0] CR_RESET = 32'h0060_0008;
    localparam logic [31:0] CR_WMASK = 32'h0068_003D;

    // Counting modes
    localparam logic [1:0] MODE_EDGE   = 2'h2;
    localparam logic [1:0] MODE_CENTER = 2'h3;

    // Sub-channel control byte (A low, B high)
    localparam int CC_FUNC  = 0;
    localparam int CC_EDGE  = 1;
    localparam int CC_IE    = 3;
    localparam int CC_DE    = 4;
    localparam logic FUNC_CAPTURE = 1'b1;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Sub-channel nibble: [2:0] mode or filter, [3] polarity
    localparam int NIB_POL = 3;
    localparam logic [2:0] OM_TOGGLE = 3'h4;
    localparam logic [2:0] OM_PWM1   = 3'h6;
    localparam logic [2:0] OM_PWM2   = 3'h7;
    localparam logic [2:0] FLT_NONE  = 3'h0;

    // Slave/master fields and codes
    localparam int SL_MODE   = 0;
    localparam int SL_SRC    = 3;
    localparam int SL_MASTER = 6;
    localparam logic [2:0] SM_TRIGGER = 3'h2;
    localparam logic [2:0] SM_GATED   = 3'h7;
    localparam logic [2:0] TSRC_1A    = 3'h6;
    localparam logic [2:0] TSRC_1B    = 3'h7;
    localparam logic [2:0] MM_SW_UPD  = 3'h0;
    localparam logic [2:0] MM_ENABLE  = 3'h1;
    localparam logic [2:0] MM_UPDATE  = 3'h2;
    localparam logic [2:0] MM_REF1A   = 3'h4;
    localparam logic [2:0] MM_REF2A   = 3'h5;
    localparam logic [2:0] MM_REF3A   = 3'h6;
    localparam logic [2:0] MM_REF1B   = 3'h7;

    // Dead-time register fields
    localparam int DT_LEN    = 0;
    localparam int DT_EN     = 8;
    localparam int DT_OUT_EN = 9;

    // Flag register: [5:0] capture flags, [6] trigger flag
    localparam int FL_TRIG = 6;

    // Reset values
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
    localparam logic [8:0]  SLAVE_RESET  = 9'h000;
    localparam logic [23:0] OUTFLT_RESET = 24'h000000;
    localparam logic [9:0]  DEAD_RESET   = 10'h000;

endpackage

// ==== hw/adt_timer.sv ====
// Capture/compare timer with complementary PWM, dead time and slave modes
// How it works
// - Mode field 2 runs the counter edge-aligned, wrapping at the reload value.
// - Mode field 3 runs the counter center-aligned, up then down.
// - Function select 1 makes a sub-channel capture; 0 keeps it compare output.
// - Edge field 01 captures rising edges; 11 captures both edges.
// - With counter enabled, a selected edge copies the count into the channel register.
// - Each capture sets a sticky flag; request raised only if enabled.
// - Output mode 4 inverts the reference output on every compare match.
// - Output mode 6 is PWM mode 1, mode 7 is PWM mode 2.
// - Polarity bit 0 leaves the output as is, 1 inverts it.
// - Complementary bit drives B as inverse of A; pair select 0 uses two-point compare.
// - Dead-time enable, with the complementary bit set, holds both outputs inactive for the programmed length.
// - Outputs reach the pins only while the main output enable is set.
// - In edge-aligned mode direction 0 counts up, 1 counts down.
// - Capture with DMA enabled pulses that channel's capture request line.
// - Compare match with DMA enabled pulses the compare request line.
// - Slave mode 2 starts the counter on an active trigger input.
// - Trigger source 7 picks filtered 1B, source 6 picks filtered 1A.
// - Slave mode 7 counts only while the gate is active; polarity 1 means low.
// - Master select 1 drives the counter enable straight onto the cascade output.
// - Filter setting 0 passes the input unfiltered; others demand longer stability.
// - A trigger start sets the trigger flag; request raised if enabled.
`timescale 1ns/10ps
`default_nettype none

module adt_timer
    import adt_pkg::*;
#(
    parameter int unsigned CNT_W = 16
)(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    output logic      [31:0]      reg_rdata,
    // Channel inputs, index 2*ch + (1 for B)
    input  wire logic [5:0]       chan_in,
    // Channel outputs and enables
    output logic      [5:0]       chan_out,
    output logic      [5:0]       chan_oe,
    // Requests and cascade
    output logic                  irq,
    output logic      [5:0]       dma_cap_req,
    output logic                  dma_cmp_req,
    output logic                  counter_enable_output
);

    logic [CNT_W-1:0]        reload;
    logic [CNT_W-1:0]        next_reload;
    logic [CNT_W-1:0]        count;
    logic [CNT_W-1:0]        next_count;
    logic [31:0]             ctrl;
    logic [31:0]             next_ctrl;
    logic                    dir;
    logic                    next_dir;
    logic [8:0]              slave;
    logic [8:0]              next_slave;
    logic [23:0]             outflt;
    logic [23:0]             next_outflt;
    logic [2:0][15:0]        chan_ctrl;
    logic [2:0][15:0]        next_chan_ctrl;
    logic [9:0]              dead;
    logic [9:0]              next_dead;
    logic [6:0]              flags;
    logic [6:0]              next_flags;
    logic [31:0]             rdata;
    logic [31:0]             next_rdata;
    logic                    trig_prev;
    logic                    uev;
    logic                    next_uev;

    logic [5:0]              filt_v;
    logic [5:0]              ref_v;
    logic [5:0]              cap_ev;
    logic [5:0]              ie_v;
    logic [5:0]              cmp_q;
    logic [5:0][CNT_W-1:0]   ccr_v;

    logic                    en;
    logic [1:0]              mode;
    logic [2:0]              slave_mode_select;
    logic [2:0]              tsrc;
    logic [2:0]              master_output_select;
    logic                    trig_raw;
    logic                    trig_start;
    logic                    step;
    logic                    wr_ctrl;
    logic                    sw_upd;

    assign en   = ctrl[CR_EN];
    assign mode = ctrl[CR_MODE +: 2];
    assign slave_mode_select  = slave[SL_MODE +: 3];
    assign tsrc = slave[SL_SRC +: 3];
    assign master_output_select  = slave[SL_MASTER +: 3];
    assign wr_ctrl = reg_write && (reg_addr == ADR_CTRL);
    assign sw_upd  = wr_ctrl && reg_wdata[CR_SW_UPD];

    // Trigger and gate: filtered, polarity-adjusted channel 1 inputs
    always_comb begin
        case (tsrc)
            TSRC_1B: trig_raw = filt_v[1] ^ outflt[4 + NIB_POL];
            TSRC_1A: trig_raw = filt_v[0] ^ outflt[NIB_POL];
            default: trig_raw = 1'b0;
        endcase
    end

    assign trig_start = (slave_mode_select == SM_TRIGGER)
                      && ((trig_raw && !trig_prev) || (wr_ctrl && reg_wdata[CR_SW_TRIG]));
    assign step = en && ((slave_mode_select != SM_GATED) || trig_raw);

    // Control, counter and flags
    always_comb begin
        next_reload    = reload;
        next_count     = count;
        next_ctrl      = ctrl;
        next_dir       = dir;
        next_slave     = slave;
        next_outflt    = outflt;
        next_chan_ctrl = chan_ctrl;
        next_dead      = dead;
        next_flags     = flags;
        next_uev       = 1'b0;
        if (reg_write) begin
            case (reg_addr)
                ADR_RELOAD:  next_reload = reg_wdata[CNT_W-1:0];
                ADR_SLAVE:   next_slave = reg_wdata[8:0];
                ADR_OUTFLT:  next_outflt = reg_wdata[23:0];
                ADR_DEAD:    next_dead = reg_wdata[9:0];
                ADR_FLAG_CLR: next_flags = flags & reg_wdata[6:0];
                ADR_CTRL: begin
                    next_ctrl = (ctrl & ~CR_WMASK) | (reg_wdata & CR_WMASK);
                    if (reg_wdata[CR_MODE +: 2] == MODE_CENTER) begin
                        if (mode != MODE_CENTER) begin
                            next_dir = 1'b0;
                        end
                    end else begin
                        next_dir = reg_wdata[CR_DIR];
                    end
                end
                default: begin
                    if (reg_addr == ADR_CHAN_CTRL) begin
                        next_chan_ctrl[0] = reg_wdata[15:0];
                    end else if (reg_addr == ADR_CHAN_CTRL + ADR_STEP) begin
                        next_chan_ctrl[1] = reg_wdata[15:0];
                    end else if (reg_addr == ADR_CHAN_CTRL + ADR_STEP + ADR_STEP) begin
                        next_chan_ctrl[2] = reg_wdata[15:0];
                    end
                end
            endcase
        end
        // Bus count write overrides stepping
        if (step) begin
            if (mode == MODE_CENTER) begin
                if (!dir) begin
                    if (count >= reload) begin
                        next_dir   = 1'b1;
                        next_count = count - 1'b1;
                        next_uev   = 1'b1;
                    end else begin
                        next_count = count + 1'b1;
                    end
                end else begin
                    if (count == '0) begin
                        next_dir   = 1'b0;
                        next_count = count + 1'b1;
                        next_uev   = 1'b1;
                    end else begin
                        next_count = count - 1'b1;
                    end
                end
            end else begin
                if (!dir) begin
                    next_count = (count >= reload) ? '0 : count + 1'b1;
                    next_uev   = (count >= reload);
                end else begin
                    next_count = (count == '0) ? reload : count - 1'b1;
                    next_uev   = (count == '0);
                end
            end
        end
        if (reg_write && (reg_addr == ADR_COUNTER)) begin
            next_count = reg_wdata[CNT_W-1:0];
        end
        if (sw_upd) begin
            next_count = '0;
            next_dir   = 1'b0;
            next_uev   = 1'b1;
        end
        if (trig_start) begin
            next_ctrl[CR_EN]   = 1'b1;
            next_flags[FL_TRIG] = 1'b1;
        end
        // Set wins over a same-cycle clear
        next_flags[5:0] = next_flags[5:0] | cap_ev;
    end

    // Read data a cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_read) begin
            case (reg_addr)
                ADR_RELOAD:  next_rdata = 32'(reload);
                ADR_COUNTER: next_rdata = 32'(count);
                ADR_CTRL:    next_rdata = {ctrl[31:28], dir, ctrl[26:0]};
                ADR_FLAGS:   next_rdata = {25'h0000000, flags};
                ADR_SLAVE:   next_rdata = {23'h000000, slave};
                ADR_OUTFLT:  next_rdata = {8'h00, outflt};
                ADR_DEAD:    next_rdata = {22'h000000, dead};
                default: begin
                    for (int k = 0; k < 3; k++) begin
                        if (reg_addr == ADR_CHAN_CTRL + 8'(4 * k)) begin
                            next_rdata = {16'h0000, chan_ctrl[k]};
                        end
                    end
                    for (int k = 0; k < 6; k++) begin
                        if (reg_addr == ADR_CCR_BASE + 8'(4 * k)) begin
                            next_rdata = 32'(ccr_v[k]);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            reload    <= CNT_W'(RELOAD_RESET);
            count     <= '0;
            ctrl      <= CR_RESET;
            dir       <= 1'b0;
            slave     <= SLAVE_RESET;
            outflt    <= OUTFLT_RESET;
            chan_ctrl <= '0;
            dead      <= DEAD_RESET;
            flags     <= 7'h00;
            rdata     <= 32'h0000_0000;
            trig_prev <= 1'b0;
            uev       <= 1'b0;
        end else begin
            reload    <= next_reload;
            count     <= next_count;
            ctrl      <= next_ctrl;
            dir       <= next_dir;
            slave     <= next_slave;
            outflt    <= next_outflt;
            chan_ctrl <= next_chan_ctrl;
            dead      <= next_dead;
            flags     <= next_flags;
            rdata     <= next_rdata;
            trig_prev <= trig_raw;
            uev       <= next_uev;
        end
    end

    // Sub-channels: filter, capture, compare reference
    for (genvar i = 0; i < 6; i++) begin : g_sub
        localparam int CH = i / 2;
        localparam int HI = i % 2;
        localparam int PR = i | 1;
        logic [7:0]       cc;
        logic [2:0]       fld;
        logic             pol;
        logic             filt;
        logic             next_filt;
        logic [7:0]       fcnt;
        logic [7:0]       next_fcnt;
        logic             sig_prev;
        logic             sig;
        logic [CNT_W-1:0] ccr;
        logic [CNT_W-1:0] next_ccr;
        logic             rf;
        logic             next_rf;
        logic             dreq;
        logic             cmp;
        logic             cap;
        logic             match;
        logic             two_pt;
        logic             pwm_act;

        assign cc  = chan_ctrl[CH][HI * 8 +: 8];
        assign fld = outflt[i * 4 +: 3];
        assign pol = outflt[i * 4 + NIB_POL];
        assign sig = filt ^ pol;
        assign cap = en && (cc[CC_FUNC] == FUNC_CAPTURE)
                   && ((cc[CC_EDGE] && sig && !sig_prev)
                   || (cc[CC_EDGE + 1] && !sig && sig_prev));
        assign match   = en && (cc[CC_FUNC] != FUNC_CAPTURE) && (count == ccr);
        assign two_pt  = ctrl[CR_COMP] && !ctrl[CR_PAIR_SEL] && (HI == 0);
        assign pwm_act = two_pt ? ((count >= ccr) && (count < ccr_v[PR])) : (count < ccr);

        always_comb begin
            next_filt = filt;
            next_fcnt = 8'h00;
            if (fld == FLT_NONE) begin
                next_filt = chan_in[i];
            end else if (chan_in[i] != filt) begin
                // Setting n needs 2^n stable clocks
                next_fcnt = fcnt + 8'h01;
                if (next_fcnt == (8'h01 << fld)) begin
                    next_filt = chan_in[i];
                    next_fcnt = 8'h00;
                end
            end
            next_ccr = ccr;
            if (reg_write && (reg_addr == ADR_CCR_BASE + 8'(4 * i))) begin
                next_ccr = reg_wdata[CNT_W-1:0];
            end
            if (cap) begin
                next_ccr = count;
            end
            next_rf = rf;
            if (cc[CC_FUNC] != FUNC_CAPTURE) begin
                case (fld)
                    OM_TOGGLE: next_rf = match ? !rf : rf;
                    OM_PWM1:   next_rf = pwm_act;
                    OM_PWM2:   next_rf = !pwm_act;
                    default:   next_rf = rf;
                endcase
            end
        end

        always_ff @(posedge clock) begin
            if (!nrst) begin
                filt     <= 1'b0;
                fcnt     <= 8'h00;
                sig_prev <= 1'b0;
                ccr      <= '0;
                rf       <= 1'b0;
                dreq     <= 1'b0;
                cmp      <= 1'b0;
            end else begin
                filt     <= next_filt;
                fcnt     <= next_fcnt;
                sig_prev <= sig;
                ccr      <= next_ccr;
                rf       <= next_rf;
                dreq     <= cap && cc[CC_DE];
                cmp      <= match && cc[CC_DE];
            end
        end

        assign filt_v[i]      = filt;
        assign ref_v[i]       = rf;
        assign cap_ev[i]      = cap;
        assign ie_v[i]        = cc[CC_IE];
        assign ccr_v[i]       = ccr;
        assign dma_cap_req[i] = dreq;
        assign cmp_q[i]       = cmp;
    end

    // Output pairs: complement, dead time, polarity, enable
    for (genvar j = 0; j < 3; j++) begin : g_out
        logic       ra;
        logic       rb;
        logic       ra_prev;
        logic [7:0] dtc;
        logic [7:0] next_dtc;
        logic       main_output_enable;
        logic       oa;
        logic       ob;

        assign ra  = ref_v[2 * j];
        assign rb  = ctrl[CR_COMP] ? !ra : ref_v[2 * j + 1];
        assign main_output_enable = dead[DT_OUT_EN];

        always_comb begin
            next_dtc = dtc;
            if (dead[DT_EN] && ctrl[CR_COMP] && (ra != ra_prev)) begin
                next_dtc = dead[DT_LEN +: 8];
            end else if (dtc != 8'h00) begin
                next_dtc = dtc - 8'h01;
            end
        end

        // Blank both sides so neither switch turns on in the gap
        assign oa = (ra && (next_dtc == 8'h00)) ^ outflt[8 * j + NIB_POL];
        assign ob = (rb && (next_dtc == 8'h00)) ^ outflt[8 * j + 4 + NIB_POL];

        always_ff @(posedge clock) begin
            if (!nrst) begin
                ra_prev          <= 1'b0;
                dtc              <= 8'h00;
                chan_out[2*j]    <= 1'b0;
                chan_out[2*j+1]  <= 1'b0;
                chan_oe[2*j]     <= 1'b0;
                chan_oe[2*j+1]   <= 1'b0;
            end else begin
                ra_prev          <= ra;
                dtc              <= next_dtc;
                chan_out[2*j]    <= main_output_enable && oa;
                chan_out[2*j+1]  <= main_output_enable && ob;
                chan_oe[2*j]     <= main_output_enable;
                chan_oe[2*j+1]   <= main_output_enable;
            end
        end
    end

    // Combinational so a slaved timer starts in the same cycle
    always_comb begin
        case (master_output_select)
            MM_SW_UPD: counter_enable_output = sw_upd;
            MM_ENABLE: counter_enable_output = en;
            MM_UPDATE: counter_enable_output = uev;
            MM_REF1A:  counter_enable_output = ref_v[0];
            MM_REF2A:  counter_enable_output = ref_v[2];
            MM_REF3A:  counter_enable_output = ref_v[4];
            MM_REF1B:  counter_enable_output = ref_v[1];
            default:   counter_enable_output = 1'b0;
        endcase
    end

    assign irq = (|(flags[5:0] & ie_v)) || (flags[FL_TRIG] && ctrl[CR_TRIG_IE]);
    assign dma_cmp_req = |cmp_q;
    assign reg_rdata   = rdata;

endmodule

`default_nettype wire

// ==== test/adt_timer_asserts.sv ====
// Port-level assertions for the timer block
`timescale 1ns/10ps
`default_nettype none
module adt_timer_asserts
    import adt_pkg::*;
(
    // Clock and register port
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    // Pins and requests
    input wire logic [5:0]  chan_out,
    input wire logic [5:0]  chan_oe,
    input wire logic        irq,
    input wire logic        counter_enable_output
);
    // Slave register copy rebuilt from bus writes
    logic [8:0] slv;
    logic [8:0] next_slv;
    always_comb begin
        next_slv = slv;
        if (reg_write && reg_addr == ADR_SLAVE) begin
            next_slv = reg_wdata[8:0];
        end
    end
    always_ff @(posedge clock) begin
        slv <= nrst ? next_slv : SLAVE_RESET;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_ctrl_wr;
        reg_write && reg_addr == ADR_CTRL && slv[8:6] == MM_ENABLE;
    endsequence
    sequence s_trig_wr;
        s_ctrl_wr ##0 reg_wdata[CR_SW_TRIG] && slv[2:0] == SM_TRIGGER;
    endsequence
    sequence s_dead_wr;
        reg_write && reg_addr == ADR_DEAD ##1 !(reg_write && reg_addr == ADR_DEAD);
    endsequence
    property p_rd_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
    property p_rd_hole; reg_read && reg_addr == 8'h08 |=> reg_rdata == 32'h0; endproperty
    property p_oe_all; chan_oe == 6'h00 || chan_oe == 6'h3F; endproperty
    property p_out_off; chan_oe == 6'h00 |-> chan_out == 6'h00; endproperty
    property p_oe_fol; s_dead_wr |=> chan_oe == {6{$past(reg_wdata[DT_OUT_EN], 2)}}; endproperty
    property p_casc;
        s_ctrl_wr ##0 !reg_wdata[CR_SW_TRIG] |=> counter_enable_output == $past(reg_wdata[CR_EN]);
    endproperty
    property p_sw_trig; s_trig_wr |=> counter_enable_output; endproperty
    property p_trig_irq; s_trig_wr ##0 reg_wdata[CR_TRIG_IE] |=> irq; endproperty
    property p_irq_hold; irq && !reg_write |=> irq; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
    a_oe_all: assert property (p_oe_all) else $error("output enables differ");
    a_out_off: assert property (p_out_off) else $error("pin driven while off");
    a_oe_fol: assert property (p_oe_fol) else $error("enable not following");
    a_casc: assert property (p_casc) else $error("cascade output wrong");
    a_sw_trig: assert property (p_sw_trig) else $error("trigger did not start");
    a_trig_irq: assert property (p_trig_irq) else $error("trigger request missing");
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped");
endmodule
bind adt_timer adt_timer_asserts u_chk (.clock, .nrst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .chan_out, .chan_oe, .irq, .counter_enable_output);
`default_nettype wire

// ==== test/adt_pulse_src.sv ====
// Pulse source model for the channel input pins
`timescale 1ns/10ps
`default_nettype none
module adt_pulse_src (
    // Clock
    input  wire logic       clock,
    // Channel pins
    output logic      [5:0] chan_in
);
    logic [5:0] lvl = 6'h00;
    assign chan_in = lvl;
    // Pins move together just after an edge
    task automatic put(input logic [5:0] v);
        @(posedge clock);
        lvl <= v;
        #1;
    endtask
endmodule
`default_nettype wire

// ==== test/advanced_timer_capture_pwm_bench.sv ====
// Self-checking bench for the timer block
`timescale 1ns/10ps
`default_nettype none
module advanced_timer_capture_pwm_bench;
    import adt_pkg::*;
    // Rows: ctrl, mode, dead, A highs, B highs (FF unchecked)
    localparam logic [39:0] ROWS [7] = '{40'h29_6_200_08_FF, 40'h29_7_200_18_FF,
        40'h29_E_200_18_FF, 40'h29_4_200_10_FF, 40'h29_6_000_00_FF,
        40'h19_6_200_10_10, 40'h19_6_302_0C_0C};
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata, v1, v2;
    logic [39:0] r;
    logic [5:0]  chan_out, chan_oe, dma_cap_req;
    logic        irq, dma_cmp_req, counter_enable_output;
    wire  [5:0]  chan_in;
    int          fails = 0, num_checks = 0, cyc = 0, nc0 = 0, nc1 = 0, ncm = 0, t1, a, b, m;
    adt_timer uut (.clock, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .chan_in, .chan_out, .chan_oe, .irq, .dma_cap_req, .dma_cmp_req, .counter_enable_output);
    adt_pulse_src src (.clock, .chan_in);
    initial begin
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        nc0 <= nc0 + dma_cap_req[0];
        nc1 <= nc1 + dma_cap_req[1];
        ncm <= ncm + dma_cmp_req;
        if (cyc == 3000) begin
            chk(cyc, 0);
            wrap_up;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= ad;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic t_capture;
        wr(ADR_CHAN_CTRL, 32'h0000_1F1B);
        wr(ADR_OUTFLT, 32'h0);
        wr(ADR_COUNTER, 32'h0);
        wr(ADR_CTRL, 32'h9);
        m = nc0;
        a = nc1;
        src.put(6'h03);
        t1 = cyc;
        repeat (6) @(posedge clock);
        rd(ADR_CCR_BASE, v1);
        src.put(6'h00);
        repeat (6) @(posedge clock);
        src.put(6'h03);
        t1 = cyc - t1;
        repeat (6) @(posedge clock);
        rd(ADR_CCR_BASE, v2);
        chk(v2 - v1, t1);
        rd(ADR_CCR_BASE + ADR_STEP, v1);
        chk(v1, v2);
        chk(nc0 - m, 2);
        chk(nc1 - a, 3);
        chk(irq, 1'b1);
        wr(ADR_FLAG_CLR, 32'h0);
        #1 chk(irq, 1'b0);
        $display("capture test done");
    endtask
    task automatic t_count;
        wr(ADR_CTRL, 32'h0800_0008);
        wr(ADR_COUNTER, 32'h100);
        wr(ADR_CTRL, 32'h0800_0009);
        rd(ADR_COUNTER, v1);
        rd(ADR_COUNTER, v2);
        chk(v1 - v2, 2);
        wr(ADR_CTRL, 32'h8);
        wr(ADR_RELOAD, 32'h10);
        wr(ADR_COUNTER, 32'hE);
        wr(ADR_CTRL, 32'hD);
        rd(ADR_COUNTER, v1);
        repeat (6) begin
            rd(ADR_COUNTER, v2);
            chk(v2 <= 32'h10 && v2 - v1 + 2 <= 4, 1'b1);
            v1 = v2;
        end
        chk(v1 < 32'h10, 1'b1);
        $display("count test done");
    endtask
    task automatic t_pwm;
        wr(ADR_RELOAD, 32'hF);
        wr(ADR_CCR_BASE, 32'h4);
        wr(ADR_CCR_BASE + ADR_STEP, 32'hC);
        wr(ADR_CHAN_CTRL, 32'h10);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            wr(ADR_CTRL, 32'h8);
            wr(ADR_OUTFLT, {28'h0, r[31:28]});
            wr(ADR_DEAD, {20'h0, r[27:16]});
            wr(ADR_COUNTER, 32'h0);
            wr(ADR_CTRL, {24'h0, r[39:32]});
            repeat (8) @(posedge clock);
            a = 0;
            b = 0;
            m = ncm;
            repeat (32) begin
                @(posedge clock);
                #1 a += chan_out[0];
                b += chan_out[1];
            end
            chk(a, r[15:8]);
            if (r[7:0] != 8'hFF) chk(b, r[7:0]);
            chk(chan_oe, {6{r[25]}});
            if (r[37]) chk(ncm - m, 2);
        end
        $display("pwm test done");
    endtask
    task automatic t_slave;
        wr(ADR_CTRL, 32'h0008_0008);
        wr(ADR_OUTFLT, 32'h0);
        wr(ADR_FLAG_CLR, 32'h0);
        src.put(6'h00);
        wr(ADR_SLAVE, 32'h7A);
        src.put(6'h01);
        repeat (6) @(posedge clock);
        chk(counter_enable_output, 1'b0);
        src.put(6'h03);
        repeat (4) @(posedge clock);
        chk(counter_enable_output, 1'b1);
        chk(irq, 1'b1);
        wr(ADR_CTRL, 32'h0008_0008);
        wr(ADR_FLAG_CLR, 32'h0);
        #1 chk(counter_enable_output, 1'b0);
        wr(ADR_CTRL, 32'h0108_0008);
        #1 chk(irq, 1'b1);
        wr(ADR_CTRL, 32'h8);
        wr(ADR_OUTFLT, 32'h8);
        src.put(6'h01);
        wr(ADR_SLAVE, 32'h37);
        wr(ADR_CTRL, 32'h9);
        rd(ADR_COUNTER, v1);
        rd(ADR_COUNTER, v2);
        chk(v2, v1);
        src.put(6'h00);
        repeat (4) @(posedge clock);
        rd(ADR_COUNTER, v1);
        rd(ADR_COUNTER, v2);
        chk(v2 - v1, 2);
        $display("slave test done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        {reg_write, reg_read, reg_addr, reg_wdata} <= '0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rd(ADR_CTRL, v1);
        chk(v1, CR_RESET);
        rd(8'h08, v1);
        chk(v1, 32'h0);
        t_capture;
        t_count;
        t_pwm;
        t_slave;
        wrap_up;
    end
endmodule
`default_nettype wire
